// >>> shared/ipc_defs.svh
// Register offsets, field positions, reset values and vector numbers of the priority block
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH

// Number of vector channels covered by the configuration window
`define IPC_NUM_VEC       128

// Register indices; the byte address on the bus is four times the index
`define IPC_IDX_BLOCK_SEL 6'h17
`define IPC_IDX_WIN_TOP   3'h3

// Block-select field position inside config_block_select
`define IPC_BLK_LSB       3
`define IPC_BLK_MSB       6

// Priority levels
`define IPC_LVL_RESET     3'h1
`define IPC_LVL_OFF       3'h0

// Fixed read answer of the spurious vector's window register
`define IPC_SPUR_READ     8'h07

// Vector numbers (byte offset from the vector base is four times these)
`define IPC_SPUR_VEC      7'h77
`define IPC_XIRQ_VEC      7'h76
`define IPC_MACH_VEC      7'h7A
`define IPC_SYS_VEC       7'h7B
`define IPC_SWI_VEC       7'h7C
`define IPC_TRAP_VEC      7'h7D
`define IPC_SPARE_VEC     7'h7E
`define IPC_RESET_VEC     7'h7F

// Channels that may hold configuration: vectors 0x04 to 0x75
`define IPC_CFG_MASK      128'h003F_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFF0

`endif

// >>> shared/ipc_pkg.sv
// Types shared by the priority configuration and decode block
package ipc_pkg;

    typedef logic [2:0] ipc_level_t;
    typedef logic [6:0] ipc_vec_t;

    // Register bus answer sequence
    typedef enum logic [1:0] {
        ipc_st_idle,
        ipc_st_fetch,
        ipc_st_done
    } ipc_bus_state_e;

endpackage : ipc_pkg

// >>> hw/ipc_level_store.sv
// Per-channel priority level storage with a registered read port
`timescale 1ns/100ps
`include "ipc_defs.svh"

module ipc_level_store #(
    parameter int              DEPTH     = 128,
    parameter int              WIDTH     = 3,
    parameter logic [DEPTH-1:0] RESET_ONE = '1
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data,
    output logic      [DEPTH*WIDTH-1:0]   all_levels
);

    logic [WIDTH-1:0] next_rd_data;

    if (DEPTH < 2 || WIDTH != 3) begin : g_bad_shape
        $error("ipc_level_store: DEPTH must be at least 2 and WIDTH 3");
    end

    // One level register per channel; unstored channels reset to zero and stay there
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] next_level;

        always_comb begin
            next_level = level;
            if (wr_en && wr_addr == ($clog2(DEPTH))'(i)) begin
                next_level = wr_data;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                level <= RESET_ONE[i] ? `IPC_LVL_RESET : `IPC_LVL_OFF;
            end else begin
                level <= next_level;
            end
        end

        assign all_levels[i*WIDTH +: WIDTH] = level;
    end

    // Read data registered so the bus answer sees a stable value
    always_comb begin
        next_rd_data = all_levels[rd_addr*WIDTH +: WIDTH];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= next_rd_data;
        end
    end

endmodule : ipc_level_store

// >>> hw/ipc_prio_decoder.sv
// Combinational winner search over all pending maskable requests
`timescale 1ns/100ps
`include "ipc_defs.svh"

module ipc_prio_decoder #(
    parameter int NUM_VEC = 128
) (
    input  wire logic [NUM_VEC*3-1:0]       levels,
    input  wire logic [NUM_VEC-1:0]         req,
    input  wire logic [2:0]                 current_processing_level,
    output logic                            win_valid,
    output logic      [$clog2(NUM_VEC)-1:0] win_vec,
    output logic      [2:0]                 win_lvl
);

    // Ascending scan with >= lets the higher vector win a tie
    always_comb begin
        logic [2:0] lvl;
        lvl       = `IPC_LVL_OFF;
        win_valid = 1'b0;
        win_vec   = '0;
        win_lvl   = `IPC_LVL_OFF;
        for (int i = 0; i < NUM_VEC; i++) begin
            lvl = levels[i*3 +: 3];
            if (req[i] && lvl != `IPC_LVL_OFF
                && lvl > current_processing_level
                && lvl >= win_lvl) begin
                win_valid = 1'b1;
                win_vec   = ($clog2(NUM_VEC))'(i);
                win_lvl   = lvl;
            end
        end
    end

endmodule : ipc_prio_decoder

// >>> hw/ipc_top.sv
// Priority configuration window, Avalon-MM slave and vector supply for 128 channels
`timescale 1ns/100ps
`include "ipc_defs.svh"

// Contract
// - Block select picks which eight of 128 channel registers fill the window.
// - Block select is the vector number's upper bits; value times four is offset.
// - Window registers zero to seven map to ascending vector addresses of the block.
// - Reset puts every implemented channel at priority level one.
// - Level zero disables a channel; one to seven are active, seven highest.
// - Unimplemented channels ignore writes and read back zero.
// - Non-maskable vectors in the window ignore writes and read back zero.
// - Spurious vector register ignores writes and always reads 0x07.
// - Both interrupt vector and reset vector requests are served.
// - A priority decoder weighs levels of all pending maskable requests.
// - A higher level request may preempt a lower one being serviced.
// - Equal levels resolve toward the higher vector address.
// - Maskable requests pass only above current level, with no unmasked non-maskable pending.
// - Vector given only on request; nothing pending yields the spurious vector.
// - The winner's level is handed over with the vector for loading.
module ipc_top #(
    parameter int            NUM_VEC   = 128,
    parameter logic [127:0]  IMPL_MASK = `IPC_CFG_MASK
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [127:0] irq_req,
    input  wire logic [5:0]  nmi_req,
    input  wire logic        cpu_i_mask,
    input  wire logic        cpu_x_mask,
    input  wire logic [2:0]  current_processing_level,
    input  wire logic        vec_req,
    input  wire logic        vec_reset_fetch,
    output logic             vec_ack,
    output logic      [8:0]  vec_offset,
    output logic      [2:0]  request_priority_level,
    output logic             vec_level_load,
    output logic             vec_is_reset,
    output logic             int_pending
);

    // Channels that really own a level register
    localparam logic [127:0] STORE_MASK = `IPC_CFG_MASK & IMPL_MASK;

    // Vector numbers of the non-maskable sources, lowest priority first
    localparam ipc_pkg::ipc_vec_t NMI_VEC [6] = '{
        `IPC_XIRQ_VEC, `IPC_MACH_VEC, `IPC_SYS_VEC,
        `IPC_SWI_VEC, `IPC_TRAP_VEC, `IPC_SPARE_VEC
    };

    if (NUM_VEC != `IPC_NUM_VEC) begin : g_bad_num
        $error("ipc_top: NUM_VEC must be 128, the window decode is fixed");
    end
    if ((IMPL_MASK & ~`IPC_CFG_MASK) != '0) begin : g_bad_impl
        $error("ipc_top: IMPL_MASK marks a channel without configuration");
    end

    // Bus side state
    ipc_pkg::ipc_bus_state_e state;
    ipc_pkg::ipc_bus_state_e next_state;
    logic                    next_waitrequest;
    logic [31:0]             next_readdata;
    logic [3:0]              blk_sel;
    logic [3:0]              next_blk_sel;

    // Address decode
    logic [5:0]              reg_idx;
    logic                    is_blk;
    logic                    is_win;
    ipc_pkg::ipc_vec_t       win_vec_sel;
    logic                    win_spur;
    logic                    win_store;
    logic [3:0]              wdata_blk;
    logic [7:0]              read_value;

    // Level storage ports
    logic                    mem_wr;
    ipc_pkg::ipc_level_t     mem_q;
    logic [NUM_VEC*3-1:0]    all_levels;

    // Decoder and vector side
    logic                    win_valid;
    ipc_pkg::ipc_vec_t       win_vec;
    ipc_pkg::ipc_level_t     win_lvl;
    logic [5:0]              nmi_eff;
    logic                    maskable_ok;
    logic                    next_vec_ack;
    logic [8:0]              next_vec_offset;
    logic [2:0]              next_level;
    logic                    next_level_load;
    logic                    next_is_reset;
    logic                    next_int_pending;

    // Word index from the byte address; low address bits are don't-care
    assign reg_idx     = avs_address[7:2];
    assign is_blk      = reg_idx == `IPC_IDX_BLOCK_SEL;
    assign is_win      = reg_idx[5:3] == `IPC_IDX_WIN_TOP;
    assign win_vec_sel = {blk_sel, reg_idx[2:0]};
    assign win_spur    = win_vec_sel == `IPC_SPUR_VEC;
    assign win_store   = STORE_MASK[win_vec_sel];
    assign wdata_blk   = avs_writedata[`IPC_BLK_MSB:`IPC_BLK_LSB];

    // Writes land on the edge where the master sees waitrequest low
    assign mem_wr = (state == ipc_pkg::ipc_st_done) && avs_write && avs_byteenable[0]
                    && is_win && win_store && !win_spur;

    ipc_level_store #(
        .DEPTH     (NUM_VEC),
        .WIDTH     (3),
        .RESET_ONE (STORE_MASK[NUM_VEC-1:0])
    ) u_store (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .wr_en      (mem_wr),
        .wr_addr    (win_vec_sel),
        .wr_data    (avs_writedata[2:0]),
        .rd_addr    (win_vec_sel),
        .rd_data    (mem_q),
        .all_levels (all_levels)
    );

    // Read answer per register; unused bits stay zero
    always_comb begin
        read_value = 8'h00;
        if (is_blk) begin
            read_value = {1'b0, blk_sel, 3'h0};
        end else if (is_win) begin
            if (win_spur) begin
                read_value = `IPC_SPUR_READ;
            end else if (win_store) begin
                read_value = {5'h00, mem_q};
            end else begin
                read_value = 8'h00;
            end
        end
    end

    // Fixed three-cycle answer keeps the memory read registered
    always_comb begin
        next_state       = state;
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        next_blk_sel     = blk_sel;
        case (state)
            ipc_pkg::ipc_st_idle: begin
                if (avs_read || avs_write) begin
                    next_state = ipc_pkg::ipc_st_fetch;
                end
            end
            ipc_pkg::ipc_st_fetch: begin
                next_state       = ipc_pkg::ipc_st_done;
                next_waitrequest = 1'b0;
                if (avs_read) begin
                    next_readdata = {24'h000000, read_value};
                end
            end
            ipc_pkg::ipc_st_done: begin
                next_state = ipc_pkg::ipc_st_idle;
                if (avs_write && avs_byteenable[0] && is_blk) begin
                    next_blk_sel = wdata_blk;
                end
            end
            default: begin
                next_state = ipc_pkg::ipc_st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state           <= ipc_pkg::ipc_st_idle;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            blk_sel         <= 4'h0;
        end else begin
            state           <= next_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
            blk_sel         <= next_blk_sel;
        end
    end

    ipc_prio_decoder #(
        .NUM_VEC (NUM_VEC)
    ) u_decoder (
        .levels                   (all_levels),
        .req                      (irq_req[NUM_VEC-1:0] & STORE_MASK[NUM_VEC-1:0]),
        .current_processing_level (current_processing_level),
        .win_valid                (win_valid),
        .win_vec                  (win_vec),
        .win_lvl                  (win_lvl)
    );

    // Non-maskable sources block every maskable one; XIRQ alone obeys its mask
    assign nmi_eff     = {nmi_req[5:1], nmi_req[0] & ~cpu_x_mask};
    assign maskable_ok = win_valid && !cpu_i_mask && (nmi_eff == 6'h00);

    // Vector chosen only at the moment of the request, from what pends then
    always_comb begin
        next_vec_ack     = 1'b0;
        next_vec_offset  = vec_offset;
        next_level       = request_priority_level;
        next_level_load  = vec_level_load;
        next_is_reset    = vec_is_reset;
        next_int_pending = (nmi_eff != 6'h00) || maskable_ok;
        if (vec_req) begin
            next_vec_ack    = 1'b1;
            next_level_load = 1'b0;
            next_is_reset   = 1'b0;
            next_vec_offset = {`IPC_SPUR_VEC, 2'b00};
            if (vec_reset_fetch) begin
                next_vec_offset = {`IPC_RESET_VEC, 2'b00};
                next_is_reset   = 1'b1;
            end else if (nmi_eff != 6'h00) begin
                for (int i = 0; i < 6; i++) begin
                    if (nmi_eff[i]) begin
                        next_vec_offset = {NMI_VEC[i], 2'b00};
                    end
                end
            end else if (maskable_ok) begin
                next_vec_offset = {win_vec, 2'b00};
                next_level      = win_lvl;
                next_level_load = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_ack                <= 1'b0;
            vec_offset             <= 9'h000;
            request_priority_level <= 3'h0;
            vec_level_load         <= 1'b0;
            vec_is_reset           <= 1'b0;
            int_pending            <= 1'b0;
        end else begin
            vec_ack                <= next_vec_ack;
            vec_offset             <= next_vec_offset;
            request_priority_level <= next_level;
            vec_level_load         <= next_level_load;
            vec_is_reset           <= next_is_reset;
            int_pending            <= next_int_pending;
        end
    end

    // Checks on the register window
    property p_blk_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && is_blk) |-> avs_readdata[6:3] == blk_sel;
    endproperty
    a_blk_read: assert property (p_blk_read) else $error("block select read mismatch");

    property p_blk_write;
        @(posedge sys_clk) disable iff (!rst_n)
        (!avs_waitrequest && avs_write && is_blk && avs_byteenable[0])
            |=> blk_sel == $past(wdata_blk);
    endproperty
    a_blk_write: assert property (p_blk_write) else $error("block select write lost");

    property p_spur_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && is_win && win_spur)
            |-> avs_readdata == {24'h000000, `IPC_SPUR_READ};
    endproperty
    a_spur_read: assert property (p_spur_read) else $error("spurious window read wrong");

    property p_zero_read;
        @(posedge sys_clk) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && is_win && !win_spur && !win_store)
            |-> avs_readdata == 32'h00000000;
    endproperty
    a_zero_read: assert property (p_zero_read) else $error("unstored channel read nonzero");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (!avs_waitrequest && avs_read && (is_blk || is_win))
            |-> avs_readdata[31:8] == 24'h000000 && avs_readdata[7] == 1'b0
                && (!is_blk || avs_readdata[2:0] == 3'h0);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("unused bits read nonzero");

    property p_bus_answer;
        @(posedge sys_clk) disable iff (!rst_n)
        (state == ipc_pkg::ipc_st_idle && (avs_read || avs_write))
            |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

    // Checks on the decoder and vector supply
    property p_win_active;
        @(posedge sys_clk) disable iff (!rst_n)
        win_valid |-> win_lvl != `IPC_LVL_OFF && win_lvl > current_processing_level;
    endproperty
    a_win_active: assert property (p_win_active) else $error("winner level not eligible");

    property p_vec_ack;
        @(posedge sys_clk) disable iff (!rst_n)
        vec_req |=> vec_ack ##1 (vec_ack == $past(vec_req));
    endproperty
    a_vec_ack: assert property (p_vec_ack) else $error("vector answer not one cycle after request");

    property p_spurious;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_req && !vec_reset_fetch && nmi_eff == 6'h00 && !maskable_ok)
            |=> vec_offset == {`IPC_SPUR_VEC, 2'b00} && !vec_level_load;
    endproperty
    a_spurious: assert property (p_spurious) else $error("spurious vector not supplied");

    property p_level_handover;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_req && !vec_reset_fetch && maskable_ok)
            |=> vec_level_load && request_priority_level == $past(win_lvl)
                && vec_offset == {$past(win_vec), 2'b00};
    endproperty
    a_level_handover: assert property (p_level_handover) else $error("winner level not handed over");

    property p_nmi_first;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_req && !vec_reset_fetch && nmi_eff != 6'h00) |=> !vec_level_load && !vec_is_reset;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("maskable beat a non-maskable request");

    property p_reset_vec;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_req && vec_reset_fetch) |=> vec_is_reset && vec_offset == {`IPC_RESET_VEC, 2'b00};
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector not supplied");

endmodule : ipc_top

// >>> tb/ipc_cpu_model.sv
// CPU side model: fetches vectors on command and keeps its own processing level
`timescale 1ns/100ps
module ipc_cpu_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       fetch,
    input  wire logic       want_reset,
    input  wire logic       cpl_wr,
    input  wire logic [2:0] cpl_val,
    output logic            vec_req,
    output logic            vec_reset_fetch,
    output logic      [2:0] current_processing_level,
    input  wire logic       vec_ack,
    input  wire logic [8:0] vec_offset,
    input  wire logic [2:0] request_priority_level,
    input  wire logic       vec_level_load,
    input  wire logic       vec_is_reset,
    output logic      [8:0] got_off,
    output logic      [2:0] got_lvl,
    output logic            got_load,
    output logic            got_rst,
    output logic            busy
);
    // One pulse per fetch; reset flag toggles between requests so a stale value never helps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_req                  <= 1'b0;
            vec_reset_fetch          <= 1'b0;
            current_processing_level <= 3'h0;
            busy                     <= 1'b0;
        end else begin
            vec_req         <= fetch && !busy;
            vec_reset_fetch <= (fetch && !busy) ? want_reset : ~vec_reset_fetch;
            if (cpl_wr) begin
                current_processing_level <= cpl_val;
            end
            if (fetch && !busy) begin
                busy <= 1'b1;
            end
            if (vec_ack) begin
                busy     <= 1'b0;
                got_off  <= vec_offset;
                got_lvl  <= request_priority_level;
                got_load <= vec_level_load;
                got_rst  <= vec_is_reset;
                // New level is taken at the vector fetch, so nesting follows from it
                if (vec_level_load) begin
                    current_processing_level <= request_priority_level;
                end
            end
        end
    end
endmodule : ipc_cpu_model

// >>> tb/interrupt_priority_config_tb_top.sv
// Self-checking bench for the priority configuration window and vector supply
`timescale 1ns/100ps
`include "ipc_defs.svh"
module interrupt_priority_config_tb_top;
    logic         sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, cpu_i_mask, cpu_x_mask;
    logic [7:0]   avs_address, rd;
    logic [31:0]  avs_writedata, avs_readdata;
    logic [3:0]   avs_byteenable;
    logic [127:0] irq_req;
    logic [5:0]   nmi_req;
    logic         vec_req, vec_reset_fetch, vec_ack, vec_level_load, vec_is_reset, int_pending;
    logic [2:0]   cpl, request_priority_level, got_lvl, cpl_val;
    logic [8:0]   vec_offset, got_off;
    logic         fetch, want_reset, cpl_wr, got_load, got_rst, busy;
    int           fail_count, tests_run, cycles;

    // Channel 0x40 left out to exercise an unimplemented slot
    ipc_top #(.NUM_VEC(128), .IMPL_MASK(`IPC_CFG_MASK & ~(128'h1 << 7'h40))) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
        .nmi_req(nmi_req), .cpu_i_mask(cpu_i_mask), .cpu_x_mask(cpu_x_mask), .current_processing_level(cpl),
        .vec_req(vec_req), .vec_reset_fetch(vec_reset_fetch), .vec_ack(vec_ack), .vec_offset(vec_offset),
        .request_priority_level(request_priority_level), .vec_level_load(vec_level_load),
        .vec_is_reset(vec_is_reset), .int_pending(int_pending));

    ipc_cpu_model cpu (
        .sys_clk(sys_clk), .rst_n(rst_n), .fetch(fetch), .want_reset(want_reset), .cpl_wr(cpl_wr),
        .cpl_val(cpl_val), .vec_req(vec_req), .vec_reset_fetch(vec_reset_fetch),
        .current_processing_level(cpl), .vec_ack(vec_ack), .vec_offset(vec_offset),
        .request_priority_level(request_priority_level), .vec_level_load(vec_level_load),
        .vec_is_reset(vec_is_reset), .got_off(got_off), .got_lvl(got_lvl), .got_load(got_load),
        .got_rst(got_rst), .busy(busy));

    // 25 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // Hang guard; the whole sequence needs under two thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Avalon access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic [3:0] be);
        @(posedge sys_clk);
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_address    <= addr;
        avs_writedata  <= {24'hA5A5A5, data};
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        chk(avs_readdata[31:8], 32'h0, "upper read lanes");
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rc(input logic [7:0] addr, input logic [7:0] exp, input string what);
        bus(1'b0, addr, 8'h00, 4'hF);
        chk({24'h0, rd}, {24'h0, exp}, what);
    endtask : rc

    // Expected window answer of a vector; spurious is fixed, unconfigurable slots read zero
    function automatic logic [7:0] exp_lvl(input logic [6:0] v, input logic [7:0] val);
        if (v == 7'h77) return 8'h07;
        return (v >= 7'h04 && v <= 7'h75 && v != 7'h40) ? val : 8'h00;
    endfunction : exp_lvl

    function automatic logic [127:0] v1(input logic [6:0] v);
        return 128'h1 << v;
    endfunction : v1

    // One vector fetch through the CPU model; lv[3] set keeps the model's current level
    task automatic fet(input logic [127:0] irq, input logic [5:0] nmi, input logic im, input logic rf,
                       input logic [3:0] lv, input logic [8:0] eoff, input logic [2:0] elvl, input logic eld);
        @(posedge sys_clk);
        irq_req    <= irq;
        nmi_req    <= nmi;
        cpu_i_mask <= im;
        want_reset <= rf;
        cpl_wr     <= !lv[3];
        cpl_val    <= lv[2:0];
        @(posedge sys_clk);
        cpl_wr <= 1'b0;
        fetch  <= 1'b1;
        @(posedge sys_clk);
        fetch <= 1'b0;
        do @(posedge sys_clk); while (busy !== 1'b0);
        chk(got_off, eoff, "vector offset");
        chk(got_load, eld, "level load");
        chk(got_rst, rf, "reset flag");
        // Pending flag lags the inputs by one cycle, so it still shows the fetch decision here
        chk(int_pending, eld || nmi != 6'h00, "pending");
        if (eld) chk(got_lvl, elvl, "level");
    endtask : fet

    initial begin
        {rst_n, avs_read, avs_write, cpu_i_mask, cpu_x_mask, fetch, want_reset, cpl_wr} = '0;
        {avs_address, avs_writedata, avs_byteenable, irq_req, nmi_req, cpl_val} = '0;
        {fail_count, tests_run, cycles} = '0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc(8'h5C, 8'h00, "block select reset");
        // Sweep all 128 slots: reset levels, then a write carrying junk upper bits
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 16; b++) begin
                bus(1'b1, 8'h5C, 8'(b << 3), 4'h1);
                for (int k = 0; k < 8; k++) begin
                    if (p == 1) bus(1'b1, 8'(8'h60 + 8'h04 * k), 8'hFD, 4'h1);
                    rc({3'h3,k[2:0],2'h0}, exp_lvl({b[3:0],k[2:0]}, p ? 8'h05 : 8'h01), "win");
                end
            end
        end
        bus(1'b1, 8'h5C, 8'hFF, 4'h1);
        rc(8'h5C, 8'h78, "block select bits");
        bus(1'b1, 8'h5C, 8'h00, 4'h0);
        bus(1'b1, 8'h00, 8'h00, 4'h1);
        rc(8'h00, 8'h00, "unmapped read");
        rc(8'h5C, 8'h78, "ignored writes");
        // Levels 0..7 on vectors 0x28..0x2F, level 6 on vector 0x70
        bus(1'b1, 8'h5C, 8'h28, 4'h1);
        for (int k = 0; k < 8; k++) bus(1'b1, 8'(8'h60 + 8'h04 * k), 8'(k), 4'h1);
        bus(1'b1, 8'h5C, 8'h70, 4'h1);
        bus(1'b1, 8'h60, 8'h06, 4'h1);
        fet(v1(7'h28), 6'h00, 1'b0, 1'b0, 4'h0, 9'h1DC, 3'h0, 1'b0);
        fet(v1(7'h2B) | v1(7'h2D), 6'h00, 1'b0, 1'b0, 4'h0, 9'h0B4, 3'h5, 1'b1);
        fet(v1(7'h2B) | v1(7'h2D) | v1(7'h2F), 6'h00, 1'b0, 1'b0, 4'h8, 9'h0BC, 3'h7, 1'b1);
        fet(v1(7'h2D), 6'h00, 1'b0, 1'b0, 4'h8, 9'h1DC, 3'h0, 1'b0);
        fet(v1(7'h10) | v1(7'h20), 6'h00, 1'b0, 1'b0, 4'h0, 9'h080, 3'h5, 1'b1);
        fet(v1(7'h2D) | v1(7'h70), 6'h00, 1'b0, 1'b0, 4'h0, 9'h1C0, 3'h6, 1'b1);
        fet(v1(7'h2D), 6'h00, 1'b1, 1'b0, 4'h0, 9'h1DC, 3'h0, 1'b0);
        fet(v1(7'h2D), 6'h08, 1'b0, 1'b0, 4'h0, 9'h1F0, 3'h0, 1'b0);
        fet(v1(7'h2D), 6'h01, 1'b0, 1'b0, 4'h0, 9'h1D8, 3'h0, 1'b0);
        // With the X bit set the lowest non-maskable source no longer blocks the winner
        cpu_x_mask <= 1'b1;
        fet(v1(7'h2D), 6'h01, 1'b0, 1'b0, 4'h0, 9'h0B4, 3'h5, 1'b1);
        fet(v1(7'h2F), 6'h21, 1'b0, 1'b0, 4'h0, 9'h1F8, 3'h0, 1'b0);
        fet(v1(7'h2F), 6'h21, 1'b0, 1'b1, 4'h0, 9'h1FC, 3'h0, 1'b0);
        end_sim();
    end
endmodule : interrupt_priority_config_tb_top
